// File: inc/eepc_pkg.sv
// Function
// - 256-byte array, one byte holds options
// - Software erase by byte only, no bulk or row
// - Wired-OR enable gated by option, POR-cleared
// - Lowest 32 bytes and option byte free, upper 223 protectable
// - Protect clear blocks upper erase and program
// - Protect state held until next reset
// - Protect bit programmed only with latch set
// - Security zero refuses test mode entry
// - Bootstrap entry erases whole array, security too
// - Security change acts only after reset
// - Stop entry forces read mode, pump off
// - Control resets to zero, bits 5:4 zero
// - Wait mode leaves running operations alone
package eepc_pkg;

	// ==========================================================
	// Register map (word aligned, byte address = index * 4)
	// ==========================================================
	localparam logic [31:0] CTRL_IDX = 32'h0000_0007; // Write control register index
	localparam logic [31:0] OPT_IDX = 32'h0000_0008; // Option byte alias
	localparam logic [31:0] STAT_IDX = 32'h0000_0009; // Status register
	localparam logic [31:0] ARR_IDX = 32'h0000_0100; // First array byte index
	localparam logic [31:0] CTRL_ADDR = CTRL_IDX << 2;
	localparam logic [31:0] OPT_ADDR = OPT_IDX << 2;
	localparam logic [31:0] STAT_ADDR = STAT_IDX << 2;
	localparam logic [31:0] ARR_ADDR = ARR_IDX << 2; // 0x400 .. 0x7FC

	// ==========================================================
	// Control register fields
	// ==========================================================
	localparam int CTRL_WOR_EN_BIT = 7;
	localparam int CTRL_SLEEP_BIT = 6;
	localparam int CTRL_CLK_OUT_BIT = 3;
	localparam int CTRL_ERS_BIT = 2;
	localparam int CTRL_LAT_BIT = 1;
	localparam int CTRL_PGM_BIT = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// ==========================================================
	// Option byte and status fields
	// ==========================================================
	localparam int OPT_PROT_BIT = 0; // Upper array protect, 1 = open
	localparam int OPT_LOCK_BIT = 1; // Security lock, 0 = secured
	localparam int STAT_PROT_BIT = 0;
	localparam int STAT_LOCK_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;
	localparam int STAT_DONE_BIT = 3;
	localparam int STAT_FAIL_BIT = 4;
	localparam int STAT_BULK_BIT = 5;

	// ==========================================================
	// Array geometry
	// ==========================================================
	localparam int ARRAY_BYTES = 256;
	localparam logic [7:0] LOWER_BYTES = 8'h20; // 32 unprotectable bytes
	localparam logic [7:0] OPT_BYTE = 8'hFF; // Option byte location
	localparam logic [7:0] LAST_BYTE = 8'hFF;
	localparam logic [7:0] ERASED = 8'hFF;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int CLK_MHZ = 40;
	localparam int T_PULSE_US = 10000; // High-voltage pulse time
	localparam int PULSE_CYCLES_DEF = T_PULSE_US * CLK_MHZ;

	// ==========================================================
	// Types
	// ==========================================================
	typedef enum logic [2:0] {
		BUS_IDLE = 3'b001,
		BUS_WR = 3'b010,
		BUS_RD = 3'b100
	} eepc_bus_t;

	typedef enum logic [2:0] {
		ST_SAMPLE = 3'b001,
		ST_IDLE = 3'b010,
		ST_BULK = 3'b100
	} eepc_state_t;

	typedef enum logic [4:0] {
		K_NONE = 5'b00001,
		K_CTRL = 5'b00010,
		K_OPT = 5'b00100,
		K_STAT = 5'b01000,
		K_ARR = 5'b10000
	} eepc_kind_t;

endpackage

// File: rtl/eepc_pulse_timer.sv
`timescale 1ns/1ps
// ==========================================================
// High-voltage pulse timer: one done pulse after CYCLES cycles
// ==========================================================
module eepc_pulse_timer #(
	parameter int CYCLES = eepc_pkg::PULSE_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic abort,
	output logic busy,
	output logic done
);
	localparam int W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] LOAD = W'(CYCLES - 1);

	logic [W-1:0] cnt_reg; // Cycles left in the pulse
	logic [W-1:0] cnt_next;
	logic busy_reg; // Pulse running
	logic busy_next;
	logic done_reg; // One-cycle end of pulse
	logic done_next;

	// Next-state: abort wins so a cleared enable never commits
	always_comb begin
		cnt_next = cnt_reg;
		busy_next = busy_reg;
		done_next = 1'b0;
		if (abort) begin
			busy_next = 1'b0;
		end else if (start) begin
			cnt_next = LOAD;
			busy_next = 1'b1;
		end else if (busy_reg) begin
			if (cnt_reg == '0) begin
				busy_next = 1'b0;
				done_next = 1'b1;
			end else begin
				cnt_next = cnt_reg - W'(1);
			end
		end
	end

	// State registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
		end
	end

	assign busy = busy_reg;
	assign done = done_reg;
endmodule

// File: rtl/eepc_ctrl.sv
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
// ==========================================================
// EEPROM program/protect controller with AHB-Lite slave
// ==========================================================
module eepc_ctrl #(
	parameter int PULSE_CYCLES = eepc_pkg::PULSE_CYCLES_DEF
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	input wire logic WOI_OPTION,
	input wire logic WIRED_OR_IRQ_PIN_N,
	input wire logic PORTB_IRQ_IN,
	input wire logic SLEEP_ENTRY_IN,
	input wire logic STOP_ENTRY,
	input wire logic BOOT_ENTRY,
	input wire logic TEST_REQ,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic WIRED_OR_IRQ_REQ,
	output logic EXT_CLK_OUT,
	output logic PUMP_ON,
	output logic TEST_GRANT
);

	// ==========================================================
	// Decode helpers
	// ==========================================================
	// Map a byte address onto a register kind; unmapped reads zero
	function automatic eepc_pkg::eepc_kind_t addr_kind(input logic [31:0] a);
		eepc_pkg::eepc_kind_t k;
		k = eepc_pkg::K_NONE;
		if (a == eepc_pkg::CTRL_ADDR) begin
			k = eepc_pkg::K_CTRL;
		end else if (a == eepc_pkg::OPT_ADDR) begin
			k = eepc_pkg::K_OPT;
		end else if (a == eepc_pkg::STAT_ADDR) begin
			k = eepc_pkg::K_STAT;
		end else if ((a[31:10] == eepc_pkg::ARR_ADDR[31:10]) && (a[1:0] == 2'h0)) begin
			k = eepc_pkg::K_ARR;
		end
		return k;
	endfunction

	// Upper part of the array, the option byte excepted
	function automatic logic is_guarded(input logic [7:0] idx);
		return (idx >= eepc_pkg::LOWER_BYTES) && (idx != eepc_pkg::OPT_BYTE);
	endfunction

	// ==========================================================
	// Storage
	// ==========================================================
	logic [7:0] mem [0:eepc_pkg::ARRAY_BYTES-1]; // Non-volatile array, never reset
	logic mem_we;
	logic [7:0] mem_addr;
	logic [7:0] mem_wdata;

	// ==========================================================
	// State
	// ==========================================================
	eepc_pkg::eepc_bus_t bus_reg; // Bus data-phase tracker
	eepc_pkg::eepc_bus_t bus_next;
	logic [31:0] addr_reg; // Address captured in address phase
	logic [31:0] addr_next;
	logic [31:0] rdata_reg; // Read data
	logic [31:0] rdata_next;
	logic ready_reg; // Registered HREADYOUT
	logic ready_next;
	eepc_pkg::eepc_state_t st_reg; // Sample / idle / bootstrap erase
	eepc_pkg::eepc_state_t st_next;
	logic [7:0] bulk_reg; // Bootstrap erase pointer
	logic [7:0] bulk_next;
	logic wor_en_reg, wor_en_next; // Wired-OR interrupt enable
	logic clk_out_reg, clk_out_next; // External clock output enable
	logic ers_reg, ers_next; // Erase select
	logic lat_reg, lat_next; // Latch control
	logic pgm_reg, pgm_next; // Program pulse enable
	logic sleep_reg, sleep_next; // Sleep entry flag copy
	logic [7:0] tgt_addr_reg, tgt_addr_next; // Latched target byte
	logic [7:0] tgt_data_reg, tgt_data_next; // Latched data
	logic tgt_ok_reg, tgt_ok_next; // A byte has been latched
	logic done_reg, done_next; // Last pulse committed
	logic fail_reg, fail_next; // Last pulse refused by protection
	logic prot_reg, prot_next; // Protect state sampled at reset
	logic lock_reg, lock_next; // Security state sampled at reset
	logic irq_reg, irq_next;
	logic grant_reg, grant_next;

	logic accept; // Address phase taken this cycle
	logic t_start;
	logic t_abort;
	logic t_busy;
	logic t_done;
	logic [7:0] ctrl_view; // Control register read image
	logic [7:0] stat_view; // Status register read image
	eepc_pkg::eepc_kind_t rd_kind;
	eepc_pkg::eepc_kind_t wr_kind;

	// ==========================================================
	// Pulse timer
	// ==========================================================
	eepc_pulse_timer #(
		.CYCLES(PULSE_CYCLES)
	) u_timer (
		.clk(CLK),
		.rst(RST),
		.start(t_start),
		.abort(t_abort),
		.busy(t_busy),
		.done(t_done)
	);

	// ==========================================================
	// Read images
	// ==========================================================
	// Bits 5:4 hard zero
	always_comb begin
		ctrl_view = 8'h00;
		ctrl_view[eepc_pkg::CTRL_WOR_EN_BIT] = wor_en_reg;
		ctrl_view[eepc_pkg::CTRL_SLEEP_BIT] = sleep_reg;
		ctrl_view[eepc_pkg::CTRL_CLK_OUT_BIT] = clk_out_reg;
		ctrl_view[eepc_pkg::CTRL_ERS_BIT] = ers_reg;
		ctrl_view[eepc_pkg::CTRL_LAT_BIT] = lat_reg;
		ctrl_view[eepc_pkg::CTRL_PGM_BIT] = pgm_reg;
		stat_view = 8'h00;
		stat_view[eepc_pkg::STAT_PROT_BIT] = prot_reg;
		stat_view[eepc_pkg::STAT_LOCK_BIT] = lock_reg;
		stat_view[eepc_pkg::STAT_BUSY_BIT] = t_busy;
		stat_view[eepc_pkg::STAT_DONE_BIT] = done_reg;
		stat_view[eepc_pkg::STAT_FAIL_BIT] = fail_reg;
		stat_view[eepc_pkg::STAT_BULK_BIT] = (st_reg == eepc_pkg::ST_BULK);
	end

	// ==========================================================
	// AHB-Lite slave: writes zero-wait, reads one wait state
	// ==========================================================
	// The read wait state lets a read right behind a write see the
	// written value, at the cost of one cycle per read.
	always_comb begin
		accept = HSEL && HTRANS[1] && HREADY;
		bus_next = eepc_pkg::BUS_IDLE;
		addr_next = addr_reg;
		rdata_next = rdata_reg;
		ready_next = 1'b1;
		rd_kind = addr_kind(addr_reg);
		if (bus_reg == eepc_pkg::BUS_RD) begin
			// Wait state: form the answer from committed state
			case (rd_kind)
				eepc_pkg::K_CTRL: rdata_next = {24'h000000, ctrl_view};
				eepc_pkg::K_OPT: rdata_next = {24'h000000, mem[eepc_pkg::OPT_BYTE]};
				eepc_pkg::K_STAT: rdata_next = {24'h000000, stat_view};
				eepc_pkg::K_ARR: rdata_next = {24'h000000, mem[addr_reg[9:2]]};
				default: rdata_next = 32'h0000_0000;
			endcase
		end else if (accept) begin
			addr_next = HADDR;
			bus_next = HWRITE ? eepc_pkg::BUS_WR : eepc_pkg::BUS_RD;
			ready_next = HWRITE;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			bus_reg <= eepc_pkg::BUS_IDLE;
			addr_reg <= 32'h0000_0000;
			rdata_reg <= 32'h0000_0000;
			ready_reg <= 1'b1;
		end else begin
			bus_reg <= bus_next;
			addr_reg <= addr_next;
			rdata_reg <= rdata_next;
			ready_reg <= ready_next;
		end
	end

	// ==========================================================
	// Control, sequencing and protection
	// ==========================================================
	always_comb begin
		st_next = st_reg;
		bulk_next = bulk_reg;
		wor_en_next = wor_en_reg & WOI_OPTION; // Forced off without option
		clk_out_next = clk_out_reg;
		ers_next = ers_reg;
		lat_next = lat_reg;
		pgm_next = pgm_reg;
		sleep_next = SLEEP_ENTRY_IN;
		tgt_addr_next = tgt_addr_reg;
		tgt_data_next = tgt_data_reg;
		tgt_ok_next = tgt_ok_reg;
		done_next = done_reg;
		fail_next = fail_reg;
		prot_next = prot_reg;
		lock_next = lock_reg;
		mem_we = 1'b0;
		mem_addr = bulk_reg;
		mem_wdata = eepc_pkg::ERASED;
		t_start = 1'b0;
		t_abort = 1'b0;
		wr_kind = addr_kind(addr_reg);

		// Software writes in the data phase
		if (bus_reg == eepc_pkg::BUS_WR) begin
			if (wr_kind == eepc_pkg::K_CTRL) begin
				wor_en_next = HWDATA[eepc_pkg::CTRL_WOR_EN_BIT] & WOI_OPTION;
				clk_out_next = HWDATA[eepc_pkg::CTRL_CLK_OUT_BIT];
				if (!pgm_reg) begin
					// Mode and latch only change while no pulse runs
					ers_next = HWDATA[eepc_pkg::CTRL_ERS_BIT];
					lat_next = HWDATA[eepc_pkg::CTRL_LAT_BIT];
					pgm_next = HWDATA[eepc_pkg::CTRL_PGM_BIT] & HWDATA[eepc_pkg::CTRL_LAT_BIT];
				end else begin
					pgm_next = HWDATA[eepc_pkg::CTRL_PGM_BIT];
				end
			end else if ((wr_kind == eepc_pkg::K_ARR || wr_kind == eepc_pkg::K_OPT) && lat_reg && !pgm_reg) begin
				// Latched byte write; option byte needs the latch too
				tgt_addr_next = (wr_kind == eepc_pkg::K_OPT) ? eepc_pkg::OPT_BYTE : addr_reg[9:2];
				tgt_data_next = HWDATA[7:0];
				tgt_ok_next = 1'b1;
			end
		end
		if (!lat_next) begin
			tgt_ok_next = 1'b0; // Read mode drops the latched byte
		end

		// Pulse start and early abort
		if (pgm_next && !pgm_reg) begin
			t_start = 1'b1;
			done_next = 1'b0;
			fail_next = 1'b0;
		end
		t_abort = pgm_reg && !pgm_next;

		// Pulse end: one byte only, never a block
		if (t_done && pgm_reg && tgt_ok_reg) begin
			if (is_guarded(tgt_addr_reg) && !prot_reg) begin
				fail_next = 1'b1; // Upper part protected
			end else begin
				mem_we = 1'b1;
				mem_addr = tgt_addr_reg;
				// Erase drives all ones, program clears bits
				mem_wdata = ers_reg ? eepc_pkg::ERASED : (mem[tgt_addr_reg] & tgt_data_reg);
				done_next = 1'b1;
			end
		end
		// Wait mode has no effect: nothing here looks at it

		case (st_reg)
			eepc_pkg::ST_SAMPLE: begin
				// Option byte read once after reset release
				prot_next = mem[eepc_pkg::OPT_BYTE][eepc_pkg::OPT_PROT_BIT];
				lock_next = mem[eepc_pkg::OPT_BYTE][eepc_pkg::OPT_LOCK_BIT];
				st_next = eepc_pkg::ST_IDLE;
			end
			eepc_pkg::ST_IDLE: begin
				if (BOOT_ENTRY) begin
					st_next = eepc_pkg::ST_BULK;
					bulk_next = 8'h00;
				end
			end
			eepc_pkg::ST_BULK: begin
				// Bootstrap wipes every byte, security bit included
				mem_we = 1'b1;
				mem_addr = bulk_reg;
				mem_wdata = eepc_pkg::ERASED;
				bulk_next = bulk_reg + 8'h01;
				if (bulk_reg == eepc_pkg::LAST_BYTE) begin
					st_next = eepc_pkg::ST_IDLE;
				end
			end
			default: begin
				st_next = eepc_pkg::ST_IDLE;
			end
		endcase

		// Stop or bootstrap: back to read mode, pump off
		if (STOP_ENTRY || st_next == eepc_pkg::ST_BULK) begin
			ers_next = 1'b0;
			lat_next = 1'b0;
			pgm_next = 1'b0;
			tgt_ok_next = 1'b0;
			t_start = 1'b0;
			t_abort = 1'b1;
		end

		// Pin-side outputs
		irq_next = wor_en_reg && (!WIRED_OR_IRQ_PIN_N || PORTB_IRQ_IN);
		grant_next = TEST_REQ && lock_reg && (st_reg != eepc_pkg::ST_SAMPLE);
	end

	// Control registers; reset clears all control bits
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_reg <= eepc_pkg::ST_SAMPLE;
			bulk_reg <= 8'h00;
			wor_en_reg <= eepc_pkg::CTRL_RESET[eepc_pkg::CTRL_WOR_EN_BIT];
			clk_out_reg <= eepc_pkg::CTRL_RESET[eepc_pkg::CTRL_CLK_OUT_BIT];
			ers_reg <= eepc_pkg::CTRL_RESET[eepc_pkg::CTRL_ERS_BIT];
			lat_reg <= eepc_pkg::CTRL_RESET[eepc_pkg::CTRL_LAT_BIT];
			pgm_reg <= eepc_pkg::CTRL_RESET[eepc_pkg::CTRL_PGM_BIT];
			sleep_reg <= 1'b0;
			tgt_addr_reg <= 8'h00;
			tgt_data_reg <= 8'h00;
			tgt_ok_reg <= 1'b0;
			done_reg <= 1'b0;
			fail_reg <= 1'b0;
			prot_reg <= 1'b0; // Protected until sampled
			lock_reg <= 1'b0; // Secured until sampled
			irq_reg <= 1'b0;
			grant_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			bulk_reg <= bulk_next;
			wor_en_reg <= wor_en_next;
			clk_out_reg <= clk_out_next;
			ers_reg <= ers_next;
			lat_reg <= lat_next;
			pgm_reg <= pgm_next;
			sleep_reg <= sleep_next;
			tgt_addr_reg <= tgt_addr_next;
			tgt_data_reg <= tgt_data_next;
			tgt_ok_reg <= tgt_ok_next;
			done_reg <= done_next;
			fail_reg <= fail_next;
			prot_reg <= prot_next;
			lock_reg <= lock_next;
			irq_reg <= irq_next;
			grant_reg <= grant_next;
		end
	end

	// Array write port; content survives reset by design
	always_ff @(posedge CLK) begin
		if (mem_we) begin
			mem[mem_addr] <= mem_wdata;
		end
	end

	// ==========================================================
	// Outputs from flip-flops, HRESP tied low
	// ==========================================================
	assign HRDATA = rdata_reg;
	assign HREADYOUT = ready_reg;
	assign HRESP = 1'b0;
	assign WIRED_OR_IRQ_REQ = irq_reg;
	assign EXT_CLK_OUT = clk_out_reg;
	assign PUMP_ON = pgm_reg; // Pump runs only with the pulse enable
	assign TEST_GRANT = grant_reg;
endmodule

// File: dv/eepc_ctrl_asserts.sv
`timescale 1ns/1ps
// ==========================================================
// Port checks for the EEPROM program/protect controller
// ==========================================================
module eepc_ctrl_asserts #(
	parameter int PULSE_CYCLES = 8
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic HSEL,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	input wire logic WOI_OPTION,
	input wire logic WIRED_OR_IRQ_PIN_N,
	input wire logic PORTB_IRQ_IN,
	input wire logic STOP_ENTRY,
	input wire logic TEST_REQ,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic WIRED_OR_IRQ_REQ,
	input wire logic PUMP_ON,
	input wire logic TEST_GRANT
);
	// One clock domain, so one default clock and reset
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	// Reads take exactly one wait state
	property p_rd_wait; HSEL && HTRANS[1] && HREADY && !HWRITE |=> !HREADYOUT ##1 HREADYOUT; endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
	// Writes never stall
	property p_wr_nowait; HSEL && HTRANS[1] && HREADY && HWRITE |=> HREADYOUT; endproperty
	a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
	// Response is always OKAY
	property p_okay; HRESP == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("error response seen");
	// Pump starts only from a write carrying latch and pulse enable
	property p_pump_start; $rose(PUMP_ON) |-> ($past(HWDATA[1:0]) == 2'b11 || $past(HWDATA[1:0], 2) == 2'b11); endproperty
	a_pump_start: assert property (p_pump_start) else $error("pump started without latch");
	// Stop entry drops the pump at the next edge
	property p_stop; STOP_ENTRY |=> !PUMP_ON; endproperty
	a_stop: assert property (p_stop) else $error("pump alive after stop");
	// Test grant needs a request one cycle before
	property p_test; TEST_GRANT |-> $past(TEST_REQ); endproperty
	a_test: assert property (p_test) else $error("test granted unasked");
	// Interrupt request needs a source and the mask option; the enable
	// that gates the request was itself gated by the option one cycle earlier
	property p_irq_src; WIRED_OR_IRQ_REQ |-> $past(!WIRED_OR_IRQ_PIN_N || PORTB_IRQ_IN) && $past(WOI_OPTION, 2); endproperty
	a_irq_src: assert property (p_irq_src) else $error("request without source");
	// Missing option keeps requests off
	property p_irq_gate; !WOI_OPTION [*2] |=> !WIRED_OR_IRQ_REQ; endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("request without option");
endmodule

bind eepc_ctrl eepc_ctrl_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (.CLK(CLK), .RST(RST), .HSEL(HSEL),
	.HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .WOI_OPTION(WOI_OPTION),
	.WIRED_OR_IRQ_PIN_N(WIRED_OR_IRQ_PIN_N), .PORTB_IRQ_IN(PORTB_IRQ_IN), .STOP_ENTRY(STOP_ENTRY),
	.TEST_REQ(TEST_REQ), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .WIRED_OR_IRQ_REQ(WIRED_OR_IRQ_REQ),
	.PUMP_ON(PUMP_ON), .TEST_GRANT(TEST_GRANT));

// File: dv/eepc_ctrl_test.sv
`timescale 1ns/1ps
// ==========================================================
// Register-level bench for the EEPROM controller
// ==========================================================
module eepc_ctrl_test;
	localparam int PC = 8; // Short pulse keeps the run brief
	localparam logic [31:0] CTRL = eepc_pkg::CTRL_ADDR;
	localparam logic [31:0] STAT = eepc_pkg::STAT_ADDR;
	localparam logic [31:0] OPT = eepc_pkg::OPT_ADDR;
	logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, woi = 1'b1, pin_n = 1'b1, portb = 1'b0;
	logic sleep = 1'b0, stop = 1'b0, boot = 1'b0, treq = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [2:0] hsize = 3'b010; // Whole words only
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, x;
	logic hreadyout, irq, ext_clk, pump, tgrant;
	int fails = 0;
	int n_checks = 0;

	// Slave ready feeds back as the bus ready
	eepc_ctrl #(.PULSE_CYCLES(PC)) DUT (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .WOI_OPTION(woi),
		.WIRED_OR_IRQ_PIN_N(pin_n), .PORTB_IRQ_IN(portb), .SLEEP_ENTRY_IN(sleep), .STOP_ENTRY(stop),
		.BOOT_ENTRY(boot), .TEST_REQ(treq), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(),
		.WIRED_OR_IRQ_REQ(irq), .EXT_CLK_OUT(ext_clk), .PUMP_ON(pump), .TEST_GRANT(tgrant));

	// ==========================================================
	// Clock and helpers
	// ==========================================================
	initial begin
		forever #12.5 clk = ~clk;
	end

	task automatic stop_test;
		if (fails == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h, wanted %h", $time, seen, exp);
		end
	endtask

	// Wait for ready under a bound; a hang ends the run
	task automatic rdy;
		int n;
		n = 0;
		@(posedge clk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 50) begin
				fails++;
				stop_test();
			end
			@(posedge clk);
		end
	endtask

	// One single transfer: address phase, then data phase
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= a;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		rdy();
		r = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask

	task automatic rc(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask

	function automatic logic [31:0] aa(input logic [7:0] i);
		return eepc_pkg::ARR_ADDR + {22'h0, i, 2'b00};
	endfunction

	// Poll status until bit b clears; bounded
	task automatic poll(input int b);
		logic [31:0] r;
		int n;
		n = 0;
		r = 32'hFFFF_FFFF;
		while (r[b] !== 1'b0) begin
			if (n > 400) begin
				fails++;
				stop_test();
			end
			ahb(1'b0, STAT, 32'h0, r);
			n++;
		end
	endtask

	// Latch, target byte, timed pulse, then outcome flags
	task automatic op(input logic [7:0] i, input logic e, input logic [7:0] d, input logic f);
		logic [31:0] r;
		wr(CTRL, {29'h0, e, 2'b10});
		wr(aa(i), {24'h0, d});
		wr(CTRL, {29'h0, e, 2'b11});
		poll(eepc_pkg::STAT_BUSY_BIT);
		ahb(1'b0, STAT, 32'h0, r);
		chk({30'h0, r[4:3]}, f ? 32'h2 : 32'h1);
		wr(CTRL, 32'h0);
	endtask

	task automatic do_rst;
		rst <= 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask

	// Bootstrap erase, then reset so the option byte is sampled
	task automatic boot_rst;
		boot <= 1'b1;
		@(posedge clk);
		boot <= 1'b0;
		@(posedge clk);
		poll(eepc_pkg::STAT_BULK_BIT);
		do_rst();
	endtask

	task automatic stat2(input logic [31:0] e);
		ahb(1'b0, STAT, 32'h0, x);
		chk({30'h0, x[1:0]}, e);
	endtask

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		do_rst();
		boot_rst();
		stat2(32'h3);
		rc(CTRL, 32'h0);
		sleep <= 1'b1;
		wr(CTRL, 32'hFE);
		rc(CTRL, 32'hCE);
		chk({31'h0, ext_clk}, 32'h1);
		// Wired-OR sources, then the option removed
		pin_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		pin_n <= 1'b1;
		portb <= 1'b1;
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		woi <= 1'b0;
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		ahb(1'b0, CTRL, 32'h0, x);
		chk({31'h0, x[7]}, 32'h0);
		portb <= 1'b0;
		woi <= 1'b1;
		wr(CTRL, 32'h0);
		// Single-byte erase leaves the neighbour alone
		op(8'h05, 1'b0, 8'h3C, 1'b0);
		op(8'h06, 1'b0, 8'hA5, 1'b0);
		op(8'h05, 1'b0, 8'h0F, 1'b0);
		rc(aa(8'h05), 32'h0C);
		op(8'h05, 1'b1, 8'h00, 1'b0);
		rc(aa(8'h05), 32'hFF);
		rc(aa(8'h06), 32'hA5);
		op(8'h80, 1'b0, 8'h11, 1'b0);
		rc(aa(8'h80), 32'h11);
		// Option byte: refused without latch, accepted with it
		// Latch dropped first, so the option write must not be taken by the pulse
		wr(CTRL, 32'h0);
		wr(OPT, 32'h0);
		wr(CTRL, 32'h3);
		poll(eepc_pkg::STAT_BUSY_BIT);
		rc(OPT, 32'hFF);
		ahb(1'b0, STAT, 32'h0, x);
		chk({30'h0, x[4:3]}, 32'h0);
		wr(CTRL, 32'h0);
		op(8'hFF, 1'b0, 8'hFC, 1'b0);
		rc(OPT, 32'hFC);
		stat2(32'h3);
		treq <= 1'b1;
		repeat (2) @(posedge clk);
		chk({31'h0, tgrant}, 32'h1);
		op(8'h81, 1'b0, 8'h22, 1'b0);
		rc(aa(8'h81), 32'h22);
		// New option takes hold only after reset
		do_rst();
		stat2(32'h0);
		repeat (2) @(posedge clk);
		chk({31'h0, tgrant}, 32'h0);
		op(8'h20, 1'b0, 8'h00, 1'b1);
		rc(aa(8'h20), 32'hFF);
		op(8'h80, 1'b1, 8'h00, 1'b1);
		rc(aa(8'h80), 32'h11);
		op(8'h1F, 1'b0, 8'h00, 1'b0);
		rc(aa(8'h1F), 32'h00);
		// Stop in mid-pulse aborts the program
		wr(CTRL, 32'h2);
		wr(aa(8'h10), 32'h0);
		wr(CTRL, 32'h3);
		stop <= 1'b1;
		@(posedge clk);
		stop <= 1'b0;
		repeat (2) @(posedge clk);
		chk({31'h0, pump}, 32'h0);
		ahb(1'b0, CTRL, 32'h0, x);
		chk({29'h0, x[2:0]}, 32'h0);
		repeat (PC + 4) @(posedge clk);
		rc(aa(8'h10), 32'hFF);
		// Unmapped place reads zero and ignores writes
		wr(32'h0000_0100, 32'h5A);
		rc(32'h0000_0100, 32'h0);
		// Bootstrap reopens security and wipes the array
		boot_rst();
		stat2(32'h3);
		rc(aa(8'h1F), 32'hFF);
		rc(aa(8'h80), 32'hFF);
		stop_test();
	end
endmodule
